//--- core/idle_standby_ctrl.sv
/*
  Idle command executor with automatic standby countdown, and the
  identify-device words 128 to 255 with the closing checksum.
  Assumes the command decoder presents each command for one cycle,
  the servo reports spindle speed, and the byte sum of words 0..127
  is supplied by the block that owns those words.
*/
`timescale 1ns/1ps
module idle_standby_ctrl
  import idle_timer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC // Core cycles per second
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] sector_count_i,
  input wire logic host_access_i,
  input wire logic spindle_at_speed_i,
  input wire sec_state_t sec_state_i,
  input wire feat_state_t feat_state_i,
  input wire logic [7:0] head_sum_i,
  input wire logic id_rd_i,
  input wire logic [7:0] id_word_i,
  output logic idle_mode_o,
  output logic standby_o,
  output logic spin_up_o,
  output logic cmd_done_o,
  output ata_status_t status_o,
  output ata_error_t error_o,
  output logic [15:0] id_data_o,
  output logic id_valid_o
);

  // Power states
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_SPINUP = 3'b010,
    ST_IDLE = 3'b100
  } pwr_state_t;

  pwr_state_t state_ff; // Current power state
  pwr_state_t nxt_state; // Next power state
  logic [27:0] presc_ff; // Prescaler toward one tick
  logic tick; // One-second countdown tick
  logic [15:0] interval_ff; // Programmed interval in seconds
  logic [15:0] count_ff; // Seconds left before standby
  logic enabled_ff; // Power-down sequence armed
  logic is_idle_cmd; // Idle command on the port
  logic accept; // Idle command taken
  logic reject; // Idle command refused while busy
  logic finish; // Idle command completes this cycle
  logic expire; // Countdown reaches zero
  logic [15:0] load_val; // Decoded interval

  // Map the timeout byte to seconds
  function automatic logic [15:0] timeout_s(input logic [7:0] v);
    logic [15:0] r;
    r = 16'h0000;
    if (v <= TO_SHORT_MAX) begin
      r = 16'(v * TO_SHORT_STEP_S); // RULE5 RULE6
    end else if (v <= TO_LONG_MAX) begin
      r = 16'((v - TO_SHORT_MAX) * TO_LONG_STEP_S); // RULE7
    end else begin
      unique case (v[1:0]) // RULE8
        2'b00: r = TO_252_S;
        2'b01: r = TO_253_S;
        2'b10: r = TO_254_S;
        default: r = TO_255_S;
      endcase
    end
    return r;
  endfunction : timeout_s

  // Byte sum of one identify word
  function automatic logic [7:0] bsum(input logic [15:0] w);
    return 8'(w[15:8] + w[7:0]);
  endfunction : bsum

  // Command decode, either code is the same request
  assign is_idle_cmd = cmd_valid_i && (cmd_code_i == CMD_IDLE || cmd_code_i == CMD_IDLE_ALT); // RULE1
  assign reject = is_idle_cmd && state_ff == ST_SPINUP;
  assign accept = is_idle_cmd && !reject;
  assign load_val = timeout_s(sector_count_i);
  assign finish = (accept && spindle_at_speed_i) || (state_ff == ST_SPINUP && spindle_at_speed_i);
  assign tick = presc_ff == 28'(TICK_CYCLES - 1);
  assign expire = state_ff == ST_IDLE && enabled_ff && tick && count_ff == 16'h0001
                  && !host_access_i && !accept;

  // Prescaler, restarted by any reload so intervals stay exact
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || accept || host_access_i || tick) begin
      presc_ff <= 28'h0000000; // RULE20
    end else begin
      presc_ff <= presc_ff + 28'h0000001;
    end
  end

  // Interval and enable, loaded by the idle command only
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      interval_ff <= 16'h0000;
      enabled_ff <= 1'b0;
    end else if (accept) begin
      interval_ff <= load_val; // RULE2
      enabled_ff <= sector_count_i != 8'h00; // RULE5
    end
  end

  // Countdown in seconds
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      count_ff <= 16'h0000;
    end else if (accept) begin
      count_ff <= load_val; // RULE2
    end else if (host_access_i) begin
      count_ff <= interval_ff; // RULE10
    end else if (tick && enabled_ff && state_ff == ST_IDLE && count_ff != 16'h0000) begin
      count_ff <= count_ff - 16'h0001;
    end
  end

  // Next power state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_STANDBY: begin
        if (accept) begin
          nxt_state = spindle_at_speed_i ? ST_IDLE : ST_SPINUP; // RULE3
        end
      end
      ST_SPINUP: begin
        if (spindle_at_speed_i) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (expire) begin
          nxt_state = ST_STANDBY; // RULE9
        end else if (accept) begin
          nxt_state = spindle_at_speed_i ? ST_IDLE : ST_SPINUP; // RULE3
        end
      end
    endcase
  end

  // State and state-derived outputs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_ff <= ST_STANDBY;
      idle_mode_o <= 1'b0;
      standby_o <= 1'b1;
      spin_up_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idle_mode_o <= nxt_state == ST_IDLE; // RULE4
      standby_o <= nxt_state == ST_STANDBY;
      spin_up_o <= nxt_state == ST_SPINUP;
    end
  end

  // Task file status and error
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      status_o <= STATUS_RST;
      error_o <= ERROR_RST;
      cmd_done_o <= 1'b0;
    end else begin
      cmd_done_o <= finish || reject;
      if (reject) begin
        status_o.err <= 1'b1; // RULE21
        error_o.abt <= 1'b1;
        // Spin-up ending in the same cycle still completes the earlier command
        if (finish) begin
          status_o.bsy <= 1'b0; // RULE21
          status_o.rdy <= 1'b1;
          status_o.dsc <= 1'b1;
        end
      end else if (finish) begin
        status_o.bsy <= 1'b0; // RULE21
        status_o.rdy <= 1'b1;
        status_o.dsc <= 1'b1;
        status_o.err <= 1'b0;
        error_o.abt <= 1'b0;
      end else if (accept) begin
        status_o.bsy <= 1'b1;
        status_o.rdy <= 1'b0;
      end
    end
  end

  // Identify word contents
  logic [15:0] w_sec; // Word 128
  logic [15:0] w_feat; // Word 129
  logic [7:0] cksum; // Checksum byte of word 255
  logic [15:0] id_word; // Selected word

  assign w_sec = {7'h00, sec_state_i.level_max, 2'h0, sec_state_i.enh_erase, sec_state_i.expired,
                  sec_state_i.frozen, sec_state_i.locked, sec_state_i.enabled,
                  sec_state_i.supported}; // RULE11
  assign w_feat = {12'h000, feat_state_i}; // RULE12
  assign cksum = 8'(8'h00 - (head_sum_i + bsum(w_sec) + bsum(w_feat) + bsum(V_SCT) + bsum(V_ROT)
                 + bsum(V_TMAJ) + bsum(V_TMIN) + bsum(V_UCMIN) + bsum(V_UCMAX) + V_SIG)); // RULE18

  // Word select
  always_comb begin
    unique case (id_word_i)
      W_SEC: id_word = w_sec;
      W_FEAT: id_word = w_feat;
      W_SCT: id_word = V_SCT; // RULE13
      W_ROT: id_word = V_ROT; // RULE14
      W_TMAJ: id_word = V_TMAJ; // RULE15
      W_TMIN: id_word = V_TMIN; // RULE16
      W_UCMIN: id_word = V_UCMIN; // RULE17
      W_UCMAX: id_word = V_UCMAX; // RULE17
      W_SUM: id_word = {cksum, V_SIG}; // RULE18
      default: id_word = 16'h0000; // RULE19
    endcase
  end

  // Registered identify read, answered the next cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      id_data_o <= 16'h0000;
      id_valid_o <= 1'b0;
    end else begin
      id_valid_o <= id_rd_i;
      if (id_rd_i) begin
        id_data_o <= id_word;
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  a_idle_decode: assert property (accept |=> !standby_o) // RULE1
    else $error("idle command did not leave standby");
  a_spin_skip: assert property (accept && spindle_at_speed_i |=> idle_mode_o && cmd_done_o && !spin_up_o) // RULE3
    else $error("spinning drive was not idle at once");
  a_timer_load: assert property (accept |=> count_ff == timeout_s($past(sector_count_i))) // RULE2
    else $error("timer not loaded from sector count");
  a_zero_off: assert property (state_ff == ST_IDLE && !enabled_ff |=> state_ff != ST_STANDBY) // RULE5
    else $error("disabled timer dropped to standby");
  a_reload_access: assert property (host_access_i && !accept |=> count_ff == interval_ff) // RULE10
    else $error("host access did not reload interval");
  a_expire_stby: assert property (expire |=> standby_o && !idle_mode_o) // RULE9
    else $error("expiry did not enter standby");
  a_done_status: assert property (cmd_done_o && !error_o.abt |-> !status_o.bsy && status_o.rdy) // RULE21
    else $error("completion status wrong");
  a_reject_abt: assert property (reject |=> error_o.abt && status_o.err && cmd_done_o) // RULE21
    else $error("reject did not flag abort");
  a_word_tmaj: assert property (id_rd_i && id_word_i == W_TMAJ |=> id_valid_o && id_data_o == 16'h101f) // RULE15
    else $error("transport major word wrong");
  a_word_sig: assert property (id_rd_i && id_word_i == W_SUM |=> id_data_o[7:0] == 8'ha5) // RULE18
    else $error("signature byte wrong");
  a_word_rsv: assert property (id_rd_i && id_word_i == 8'hd1 |=> id_data_o == 16'h0000) // RULE19
    else $error("reserved word not zero");
  a_tick_step: assert property (tick && !host_access_i && !accept |=> presc_ff == 28'h0000000 ##1
                                presc_ff == 28'h0000001 || $past(host_access_i) || $past(accept)) // RULE20
    else $error("prescaler did not restart");
  a_long_code: assert property (accept && sector_count_i == 8'hfd |=> count_ff == 16'h7080) // RULE8
    else $error("code 253 not eight hours");

endmodule : idle_standby_ctrl

//--- core/idle_timer_pkg.sv
/*
  Constants, field layouts and carrier types for the idle command and
  standby timer block, plus the tail of the identify-device data.
  Assumes one 200 MHz core clock and a synchronous active-high reset.
*/
// Contract
// RULE1: Decode E3h or 97h as idle.
// RULE2: Idle enters idle mode, loads timer, starts.
// RULE3: Spin up unless already spinning.
// RULE4: In idle, keep spinning, serve commands.
// RULE5: Timeout zero disables power-down.
// RULE6: Values 1..240 give value times 5 s.
// RULE7: Values 241..251 give (value-240) times 30 min.
// RULE8: Codes 252..255 map to fixed special intervals.
// RULE9: Expiry without host access enters standby.
// RULE10: Host access reloads the full interval.
// RULE11: Word 128 reports security state bits.
// RULE12: Word 129 reports live feature settings.
// RULE13: Word 206 reports SCT support 003Dh.
// RULE14: Rotation rate word returns 1C20h.
// RULE15: Word 222 returns 101Fh.
// RULE16: Word 223 returns 0021h.
// RULE17: Words 234/235 return 0001h and 03E0h.
// RULE18: Word 255: A5 signature, checksum high byte.
// RULE19: Unsupported or reserved words read zero.
// RULE20: Countdown tick from prescaled core clock.
// RULE21: Done clears BSY, sets RDY; reject sets ABT/ERR.
package idle_timer_pkg;
  // Command codes
  localparam logic [7:0] CMD_IDLE = 8'he3;
  localparam logic [7:0] CMD_IDLE_ALT = 8'h97;
  // Timing: one countdown tick per second
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_PERIOD_NS = 1000000000;
  localparam int unsigned TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Timeout encoding, intervals in seconds
  localparam logic [7:0] TO_SHORT_MAX = 8'hf0;
  localparam logic [7:0] TO_LONG_MAX = 8'hfb;
  localparam logic [15:0] TO_SHORT_STEP_S = 16'h0005;
  localparam logic [15:0] TO_LONG_STEP_S = 16'h0708;
  localparam logic [15:0] TO_252_S = 16'h04ec;
  localparam logic [15:0] TO_253_S = 16'h7080;
  localparam logic [15:0] TO_254_S = 16'h04f6;
  localparam logic [15:0] TO_255_S = 16'h04fb;
  // Identify word indices and fixed contents
  localparam logic [7:0] W_SEC = 8'h80;
  localparam logic [7:0] W_FEAT = 8'h81;
  localparam logic [7:0] W_SCT = 8'hce;
  localparam logic [7:0] W_ROT = 8'hd9;
  localparam logic [7:0] W_TMAJ = 8'hde;
  localparam logic [7:0] W_TMIN = 8'hdf;
  localparam logic [7:0] W_UCMIN = 8'hea;
  localparam logic [7:0] W_UCMAX = 8'heb;
  localparam logic [7:0] W_SUM = 8'hff;
  localparam logic [15:0] V_SCT = 16'h003d;
  localparam logic [15:0] V_ROT = 16'h1c20;
  localparam logic [15:0] V_TMAJ = 16'h101f;
  localparam logic [15:0] V_TMIN = 16'h0021;
  localparam logic [15:0] V_UCMIN = 16'h0001;
  localparam logic [15:0] V_UCMAX = 16'h03e0;
  localparam logic [7:0] V_SIG = 8'ha5;
  // Security state as reported in word 128
  typedef struct packed {
    logic level_max;
    logic enh_erase;
    logic expired;
    logic frozen;
    logic locked;
    logic enabled;
    logic supported;
  } sec_state_t;
  // Live feature settings as reported in word 129
  typedef struct packed {
    logic auto_reassign;
    logic reverting;
    logic look_ahead;
    logic wr_cache;
  } feat_state_t;
  // Task file status byte, bit 7 first
  typedef struct packed {
    logic bsy;
    logic rdy;
    logic df;
    logic dsc;
    logic drq;
    logic cor;
    logic idx;
    logic err;
  } ata_status_t;
  // Task file error byte, bit 7 first
  typedef struct packed {
    logic crc;
    logic unc;
    logic rsv5;
    logic idn;
    logic rsv3;
    logic abt;
    logic ton;
    logic amn;
  } ata_error_t;
  // Reset values
  localparam ata_status_t STATUS_RST = 8'h40;
  localparam ata_error_t ERROR_RST = 8'h00;
endpackage : idle_timer_pkg

//--- dv/spindle_model.sv
/*
  Behavioural spindle servo standing beside the idle block.
  Assumes the same core clock and synchronous reset as the block.
*/
`timescale 1ns/1ps
module spindle_model #(
  parameter int unsigned SPIN_CYC = 8 // Cycles needed to reach speed
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic spin_up_i,
  input wire logic standby_i,
  output logic at_speed_o
);
  int unsigned cnt_ff; // Spin-up progress

  // Spin up only on request, coast down whenever the drive is in standby
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || standby_i) begin
      cnt_ff <= 0;
      at_speed_o <= 1'b0;
    end else if (spin_up_i && !at_speed_o) begin
      cnt_ff <= cnt_ff + 1;
      at_speed_o <= (cnt_ff + 1 >= SPIN_CYC);
    end
  end
endmodule : spindle_model

//--- dv/idle_standby_ctrl_bench.sv
/*
  Self-checking bench for the idle command and standby countdown block.
  Assumes a short countdown tick and the spindle model as servo.
*/
`timescale 1ns/1ps
module idle_standby_ctrl_bench;
  import idle_timer_pkg::*;
  localparam int unsigned TK = 4; // Core cycles per countdown second
  logic clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, host = 1'b0, id_rd = 1'b0;
  logic at_speed, idle_m, stby, spin_up, done, id_valid;
  logic [7:0] code = 8'h00, sc = 8'h00, id_word = 8'h00, head_sum = 8'h3c;
  sec_state_t sec = 7'h5b; // Mixed security bits
  feat_state_t feat = 4'ha; // Mixed feature bits
  ata_status_t st;
  ata_error_t er;
  logic [15:0] id_data;
  int n_errors = 0, n_checks = 0, n;

  always #2.5 clk = ~clk;

  idle_standby_ctrl #(.TICK_CYCLES(TK)) i_dut (.ref_clk_i(clk), .srst_i(srst), .cmd_valid_i(cmd_valid),
    .cmd_code_i(code), .sector_count_i(sc), .host_access_i(host), .spindle_at_speed_i(at_speed),
    .sec_state_i(sec), .feat_state_i(feat), .head_sum_i(head_sum), .id_rd_i(id_rd), .id_word_i(id_word),
    .idle_mode_o(idle_m), .standby_o(stby), .spin_up_o(spin_up), .cmd_done_o(done), .status_o(st),
    .error_o(er), .id_data_o(id_data), .id_valid_o(id_valid));

  spindle_model i_servo (.ref_clk_i(clk), .srst_i(srst), .spin_up_i(spin_up), .standby_i(stby),
    .at_speed_o(at_speed));

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // One-cycle command pulse
  task automatic send(input logic [7:0] c, input logic [7:0] v);
    @(negedge clk);
    cmd_valid = 1'b1;
    code = c;
    sc = v;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : send

  // Bounded wait for the completion pulse
  task automatic wait_done();
    n = 0;
    while (done !== 1'b1) begin
      n++;
      if (n > 60) begin
        check("done wait", 16'h0, 16'h1);
        wrap_up();
      end
      @(negedge clk);
    end
  endtask : wait_done

  task automatic idle_cmd(input logic [7:0] c, input logic [7:0] v);
    send(c, v);
    wait_done();
  endtask : idle_cmd

  task automatic wait_stby(input int lim);
    n = 0;
    while (stby !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    // Bound used up: count it and close the run
    if (stby !== 1'b1) begin
      check("standby wait", 16'h0, 16'h1);
      wrap_up();
    end
  endtask : wait_stby

  task automatic hit();
    @(negedge clk);
    host = 1'b1;
    @(negedge clk);
    host = 1'b0;
  endtask : hit

  // Interval from completion to standby, spindle already turning
  task automatic measure(input logic [7:0] v, input int secs);
    idle_cmd(8'he3, 8'h00);
    idle_cmd(8'he3, v);
    wait_stby(secs * TK + 10);
    check("interval", 16'(n + 2 >= secs * TK && n <= secs * TK + 2), 16'h1);
  endtask : measure

  // Expected identify word, checksum included
  function automatic logic [15:0] ew(input int w);
    logic [7:0] s;
    logic [15:0] e;
    case (w)
      128: return {7'h00, sec[6], 2'h0, sec[5:0]};
      129: return {12'h000, feat};
      206: return 16'h003d;
      217: return 16'h1c20;
      222: return 16'h101f;
      223: return 16'h0021;
      234: return 16'h0001;
      235: return 16'h03e0;
      255: begin
        s = head_sum + 8'ha5;
        for (int k = 128; k < 255; k++) begin
          e = ew(k);
          s = s + e[15:8] + e[7:0];
        end
        return {-s, 8'ha5};
      end
      default: return 16'h0000;
    endcase
  endfunction : ew

  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    check("reset", {5'h00, idle_m, stby, spin_up, st}, 16'h0240);
    check("reset error", {8'h00, er}, 16'h0000);
    // Spin-up from standby, second command refused meanwhile
    send(8'h97, 8'h01);
    check("spin_up", {15'h0, spin_up}, 16'h1);
    idle_cmd(8'he3, 8'h01);
    check("refuse", {13'h0000, idle_m, er.abt, st.err}, 16'h3);
    cyc(1);
    check("done pulse", {15'h0, done}, 16'h0);
    wait_done();
    check("idle", {11'h000, idle_m, stby, spin_up, st.bsy, st.rdy}, 16'h11);
    $display("test spin-up done");
    // Spinning drive: no spin-up, served at once
    idle_cmd(8'he3, 8'h01);
    check("spinning", {11'h000, idle_m, spin_up, st.bsy, st.rdy, st.err}, 16'h12);
    $display("test spinning done");
    // Timeout codes
    measure(8'h01, 5);
    measure(8'hf0, 1200);
    measure(8'hf1, 1800);
    measure(8'hfc, 1260);
    measure(8'hfe, 1270);
    measure(8'hff, 1275);
    $display("test intervals done");
    // Host access reloads; access in standby does not wake
    idle_cmd(8'he3, 8'h00);
    idle_cmd(8'he3, 8'h01);
    cyc(15);
    hit();
    cyc(14);
    check("reload", {14'h0000, idle_m, stby}, 16'h2);
    wait_stby(12);
    check("expired", {15'h0, stby}, 16'h1);
    hit();
    cyc(3);
    check("no wake", {14'h0000, idle_m, stby}, 16'h1);
    $display("test reload done");
    // Eight-hour code stays idle over a short run
    idle_cmd(8'h97, 8'hfd);
    cyc(40);
    check("long code", {14'h0000, idle_m, stby}, 16'h2);
    // Zero disables, foreign code ignored
    idle_cmd(8'he3, 8'h00);
    send(8'he1, 8'h01);
    cyc(200);
    check("disabled", {14'h0000, idle_m, stby}, 16'h2);
    $display("test disable done");
    // Identify words, all indices
    for (int w = 0; w < 256; w++) begin
      @(negedge clk);
      id_rd = 1'b1;
      id_word = 8'(w);
      @(negedge clk);
      id_rd = 1'b0;
      check("id_valid", {15'h0, id_valid}, 16'h1);
      check("id word", id_data, ew(w));
    end
    $display("test identify done");
    wrap_up();
  end
endmodule : idle_standby_ctrl_bench
